// >>> reset_and_interrupt_control.sv
/*
  reset sequencing and interrupt control with apb register access.
  assumes the cpu core fetches vectors, pushes the stack and reports instruction and exception events as pulses.
*/
// Overview of operation
// (RULE_01) reset pin low halts core, holds reset
// (RULE_02) reset handling starts on pin rising edge
// (RULE_03) pin low 20 ms powerup, 10 cycles running
// (RULE_04) exit reset: init state, set global mask
// (RULE_05) fetch reset vector at 0..3, run there
// (RULE_06) block all interrupts until first instruction
// (RULE_07) watchdog overflow resets like the pin
// (RULE_08) nonmaskable highest, ignores mask bits
// (RULE_09) maskable sources two levels, arbitrate simultaneous
// (RULE_10) seven external, 36 internal, own vectors
// (RULE_11) trap sets global, plus aux when select 0
// (RULE_12) trap vector from number 0 to 3
// (RULE_13) word accesses force address bit zero
// (RULE_14) three enable levels from masks and select
// (RULE_15) each request pin edge or level independently
// (RULE_16) control bit 2 picks nonmaskable edge
// (RULE_17) control bit 3 makes aux bit user bit
// (RULE_18) control resets to 09, kept in soft standby
// (RULE_19) priority a bits 7..4 set request groups
// (RULE_20) priority registers reset to zero
// (RULE_21) status writes zero-only clear flags
// (RULE_22) flag sets by sense, clears read-write or accept
// (RULE_23) enable bits gate requests, reset zero
// (RULE_24) sense bit 0 level, 1 falling edge
// (RULE_25) requests vectors 12..17, nonmaskable 7
// (RULE_26) same level: lowest vector number first
`default_nettype none
module reset_and_interrupt_control #(
  parameter int num_int = intc_pkg::num_internal
) (
  input  wire logic                      ref_clk_i,
  input  wire logic                      reset_n_i,
  input  wire logic                      chip_init_pin_n_i,
  input  wire logic                      hw_standby_n_i,
  input  wire logic                      soft_standby_i,
  input  wire logic                      watchdog_unit_overflow_i,
  input  wire logic                      nonmaskable_pin_i,
  input  wire logic [5:0]                req_pin_n_i,
  input  wire logic [num_int-1:0]        int_req_i,
  input  wire logic [num_int-1:0]        int_level_i,
  input  wire logic                      global_mask_i,
  input  wire logic                      aux_mask_bit_i,
  input  wire logic                      instr_done_i,
  input  wire logic                      exc_taken_i,
  input  wire logic [5:0]                exc_vector_i,
  input  wire logic                      trap_instruction_i,
  input  wire logic [1:0]                trap_num_i,
  input  wire logic [23:0]               word_addr_i,
  input  wire logic                      word_access_i,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [21:0]               paddr,
  input  wire logic [31:0]               pwdata,
  input  wire logic [3:0]                pstrb,
  output logic [31:0]                    prdata,
  output logic                           pready,
  output logic                           pslverr,
  output logic                           core_hold_o,
  output logic                           core_init_o,
  output logic                           set_global_mask_o,
  output logic                           set_aux_mask_o,
  output logic                           vector_fetch_o,
  output logic [5:0]                     vector_num_o,
  output logic [23:0]                    vector_addr_o,
  output logic                           irq_req_o,
  output logic [5:0]                     irq_vector_o,
  output logic [23:0]                    bus_addr_o
);
  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [7:0] sync_a;
  logic [7:0] sync_b;
  logic [7:0] sync_c;
  logic       init_sync_a;
  logic       init_sync_b;
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sync_a      <= 8'hff;
      sync_b      <= 8'hff;
      sync_c      <= 8'hff;
      init_sync_a <= 1'b0;
      init_sync_b <= 1'b0;
    end else begin
      sync_a      <= {watchdog_unit_overflow_i, nonmaskable_pin_i, req_pin_n_i};
      sync_b      <= sync_a;
      sync_c      <= sync_b;
      init_sync_a <= chip_init_pin_n_i & hw_standby_n_i;
      init_sync_b <= init_sync_a;
    end
  end
  logic [5:0] req_lvl_n;
  logic [5:0] req_prev_n;
  logic       nmi_now;
  logic       nmi_prev;
  logic       wdt_ovf;
  assign req_lvl_n  = sync_b[5:0];
  assign req_prev_n = sync_c[5:0];
  assign nmi_now    = sync_b[6];
  assign nmi_prev   = sync_c[6];
  assign wdt_ovf    = sync_b[7] & ~sync_c[7];
  // ------------------------------------------------------------
  // reset sequencer
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    st_reset  = 4'b0001,
    st_init   = 4'b0010,
    st_first  = 4'b0100,
    st_run    = 4'b1000
  } seq_type;
  seq_type seq;
  seq_type next_seq;
  logic    chip_rst;
  assign chip_rst = ~init_sync_b | wdt_ovf; // RULE_07
  always_comb begin
    next_seq = seq;
    case (seq)
      st_reset: begin
        if (!chip_rst) begin
          next_seq = st_init; // RULE_02
        end
      end
      st_init:  next_seq = st_first;
      st_first: begin
        if (instr_done_i) begin
          next_seq = st_run;
        end
      end
      st_run:   next_seq = st_run;
      default:  next_seq = st_reset;
    endcase
    if (chip_rst) begin
      next_seq = st_reset; // RULE_01
    end
  end
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      seq <= st_reset;
    end else begin
      seq <= next_seq;
    end
  end
  logic regs_rst;
  assign regs_rst    = (seq == st_reset);
  assign core_hold_o = regs_rst; // RULE_01
  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [7:0] system_control;
  logic [7:0] request_sense_select;
  logic [7:0] request_enable;
  logic [7:0] priority_level_a;
  logic [7:0] priority_level_b;
  logic [5:0] request_flag;
  logic [5:0] flag_seen;
  logic       wr_en;
  logic       rd_en;
  logic       hit;
  assign pready  = 1'b1;
  assign wr_en   = psel & penable & pwrite & pstrb[0];
  assign rd_en   = psel & penable & ~pwrite;
  function automatic logic is_addr(input logic [21:0] a, input logic [21:0] b);
    return a == b;
  endfunction
  assign hit = is_addr(paddr, intc_pkg::system_control_addr) | is_addr(paddr, intc_pkg::request_sense_select_addr)
             | is_addr(paddr, intc_pkg::request_enable_addr) | is_addr(paddr, intc_pkg::request_status_addr)
             | is_addr(paddr, intc_pkg::priority_level_a_addr) | is_addr(paddr, intc_pkg::priority_level_b_addr)
             | is_addr(paddr, intc_pkg::core_state_addr) | is_addr(paddr, intc_pkg::vector_state_addr);
  assign pslverr = psel & penable & ~hit;
  // soft standby has no effect on these registers
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      system_control       <= intc_pkg::system_control_rst;
      request_sense_select <= intc_pkg::zero_rst;
      request_enable       <= intc_pkg::zero_rst;
      priority_level_a     <= intc_pkg::zero_rst;
      priority_level_b     <= intc_pkg::zero_rst;
    end else if (regs_rst) begin
      system_control       <= intc_pkg::system_control_rst; // RULE_18
      request_sense_select <= intc_pkg::zero_rst; // RULE_24
      request_enable       <= intc_pkg::zero_rst; // RULE_23
      priority_level_a     <= intc_pkg::zero_rst; // RULE_20
      priority_level_b     <= intc_pkg::zero_rst; // RULE_20
    end else if (wr_en) begin
      if (is_addr(paddr, intc_pkg::system_control_addr)) system_control <= pwdata[7:0]; // RULE_16 RULE_17
      if (is_addr(paddr, intc_pkg::request_sense_select_addr)) request_sense_select <= pwdata[7:0];
      if (is_addr(paddr, intc_pkg::request_enable_addr)) request_enable <= pwdata[7:0];
      if (is_addr(paddr, intc_pkg::priority_level_a_addr)) priority_level_a <= pwdata[7:0];
      if (is_addr(paddr, intc_pkg::priority_level_b_addr)) priority_level_b <= pwdata[7:0];
    end
  end
  // ------------------------------------------------------------
  // request flags
  // ------------------------------------------------------------
  logic [5:0] flag_set;
  logic [5:0] flag_clr;
  logic       status_wr;
  logic       status_rd;
  assign status_wr = wr_en & is_addr(paddr, intc_pkg::request_status_addr);
  assign status_rd = rd_en & is_addr(paddr, intc_pkg::request_status_addr);
  genvar gi;
  generate
    for (gi = 0; gi < intc_pkg::num_req; gi++) begin : g_flag
      logic accepted;
      assign accepted = exc_taken_i && exc_vector_i == intc_pkg::req_vector_base + 6'(gi); // RULE_25
      assign flag_set[gi] = request_sense_select[gi] ? (req_prev_n[gi] & ~req_lvl_n[gi]) // RULE_15 RULE_24
                                                     : ~req_lvl_n[gi]; // RULE_22
      assign flag_clr[gi] = (status_wr & flag_seen[gi] & ~pwdata[gi]) // RULE_21
                          | (accepted & (request_sense_select[gi] | req_lvl_n[gi])); // RULE_22
    end
  endgenerate
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      request_flag <= 6'h00;
      flag_seen    <= 6'h00;
    end else if (regs_rst) begin
      request_flag <= 6'h00;
      flag_seen    <= 6'h00;
    end else begin
      request_flag <= flag_set | (request_flag & ~flag_clr); // RULE_21 RULE_22
      if (status_rd) begin
        flag_seen <= request_flag;
      end else begin
        flag_seen <= flag_seen & request_flag;
      end
    end
  end
  // ------------------------------------------------------------
  // nonmaskable edge
  // ------------------------------------------------------------
  logic nmi_pend;
  logic nmi_edge;
  assign nmi_edge = system_control[intc_pkg::nonmaskable_edge_sel_pos] ? (nmi_now & ~nmi_prev) // RULE_16
                                                                       : (~nmi_now & nmi_prev);
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      nmi_pend <= 1'b0;
    end else if (regs_rst) begin
      nmi_pend <= 1'b0;
    end else if (nmi_edge) begin
      nmi_pend <= 1'b1;
    end else if (exc_taken_i && exc_vector_i == intc_pkg::nmi_vector_num) begin
      nmi_pend <= 1'b0;
    end
  end
  // ------------------------------------------------------------
  // arbitration
  // ------------------------------------------------------------
  function automatic logic pri_of(input int src, input logic [7:0] pa);
    case (src)
      0:       return pa[7];
      1:       return pa[6];
      2, 3:    return pa[5];
      default: return pa[4];
    endcase
  endfunction
  logic       en_lo;
  logic       en_hi_only;
  logic       sel_valid;
  logic [5:0] sel_vec;
  logic       sel_hi;
  always_comb begin
    // three enable levels: global mask, aux mask when used as mask
    en_lo      = ~global_mask_i; // RULE_14
    en_hi_only = global_mask_i & ~aux_mask_bit_i & ~system_control[intc_pkg::aux_bit_select_pos]; // RULE_14 RULE_17
    sel_valid  = 1'b0;
    sel_vec    = intc_pkg::reset_vector_num;
    sel_hi     = 1'b0;
    for (int i = intc_pkg::num_req - 1; i >= 0; i--) begin
      if (request_flag[i] & request_enable[i] & (en_lo | (en_hi_only & pri_of(i, priority_level_a)))) begin // RULE_19 RULE_23
        if (!sel_valid || !sel_hi || pri_of(i, priority_level_a)) begin
          sel_valid = 1'b1;
          sel_hi    = pri_of(i, priority_level_a); // RULE_09
          sel_vec   = intc_pkg::req_vector_base + 6'(i); // RULE_26
        end
      end
    end
    for (int j = num_int - 1; j >= 0; j--) begin
      if (int_req_i[j] & (en_lo | (en_hi_only & int_level_i[j]))) begin
        if (!(sel_valid && sel_hi && !int_level_i[j]) && !(sel_valid && (sel_hi == int_level_i[j])
            && sel_vec < intc_pkg::int_vector_base)) begin
          sel_valid = 1'b1;
          sel_hi    = int_level_i[j]; // RULE_09
          sel_vec   = intc_pkg::int_vector_base + 6'(j); // RULE_10 RULE_26
        end
      end
    end
    if (nmi_pend) begin
      sel_valid = 1'b1;
      sel_vec   = intc_pkg::nmi_vector_num; // RULE_08
    end
  end
  // ------------------------------------------------------------
  // core outputs
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_req_o         <= 1'b0;
      irq_vector_o      <= intc_pkg::reset_vector_num;
      core_init_o       <= 1'b0;
      vector_fetch_o    <= 1'b0;
      vector_num_o      <= intc_pkg::reset_vector_num;
      vector_addr_o     <= intc_pkg::reset_vector_lo;
      set_global_mask_o <= 1'b0;
      set_aux_mask_o    <= 1'b0;
      bus_addr_o        <= intc_pkg::reset_vector_lo;
    end else begin
      irq_req_o    <= sel_valid & (seq == st_run); // RULE_06
      irq_vector_o <= sel_vec;
      core_init_o  <= (seq == st_init); // RULE_04
      bus_addr_o   <= word_access_i ? {word_addr_i[23:1], 1'b0} : word_addr_i; // RULE_13
      if (seq == st_init) begin
        vector_fetch_o    <= 1'b1; // RULE_05
        vector_num_o      <= intc_pkg::reset_vector_num;
        vector_addr_o     <= intc_pkg::reset_vector_lo;
        set_global_mask_o <= 1'b1; // RULE_04
        set_aux_mask_o    <= 1'b0;
      end else if (trap_instruction_i && seq == st_run) begin
        vector_fetch_o    <= 1'b1;
        vector_num_o      <= intc_pkg::trap_vector_base + {4'h0, trap_num_i}; // RULE_12
        vector_addr_o     <= {16'h0000, intc_pkg::trap_vector_base + {4'h0, trap_num_i}, 2'b00};
        set_global_mask_o <= 1'b1; // RULE_11
        set_aux_mask_o    <= ~system_control[intc_pkg::aux_bit_select_pos]; // RULE_11
      end else if (exc_taken_i && seq == st_run) begin
        vector_fetch_o    <= 1'b1;
        vector_num_o      <= exc_vector_i;
        vector_addr_o     <= {16'h0000, exc_vector_i, 2'b00};
        set_global_mask_o <= 1'b1;
        set_aux_mask_o    <= ~system_control[intc_pkg::aux_bit_select_pos];
      end else begin
        vector_fetch_o    <= 1'b0;
        set_global_mask_o <= 1'b0;
        set_aux_mask_o    <= 1'b0;
      end
    end
  end
  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  always_comb begin
    prdata = intc_pkg::apb_zero;
    if (rd_en) begin
      if (is_addr(paddr, intc_pkg::system_control_addr)) prdata[7:0] = system_control;
      if (is_addr(paddr, intc_pkg::request_sense_select_addr)) prdata[7:0] = request_sense_select;
      if (is_addr(paddr, intc_pkg::request_enable_addr)) prdata[7:0] = request_enable;
      if (is_addr(paddr, intc_pkg::request_status_addr)) prdata[5:0] = request_flag;
      if (is_addr(paddr, intc_pkg::priority_level_a_addr)) prdata[7:0] = priority_level_a;
      if (is_addr(paddr, intc_pkg::priority_level_b_addr)) prdata[7:0] = priority_level_b;
      if (is_addr(paddr, intc_pkg::core_state_addr)) prdata[7:0] = {3'b000, nmi_pend, seq};
      if (is_addr(paddr, intc_pkg::vector_state_addr)) prdata[7:0] = {sel_valid, sel_hi, sel_vec};
    end
  end
endmodule
`default_nettype wire

// >>> intc_pkg.sv
/*
  controller constants: register map, fields, reset values, vectors.
  assumes an apb bus with 32-bit data.
*/
`default_nettype none
package intc_pkg;
  // ------------------------------------------------------------
  // register byte addresses (every offset a multiple of four: index times four)
  // ------------------------------------------------------------
  localparam logic [19:0] system_control_idx       = 20'hee012;
  localparam logic [19:0] request_sense_select_idx = 20'hee014;
  localparam logic [19:0] request_enable_idx       = 20'hee015;
  localparam logic [19:0] request_status_idx       = 20'hee016;
  localparam logic [19:0] priority_level_a_idx     = 20'hee018;
  localparam logic [19:0] priority_level_b_idx     = 20'hee019;
  localparam logic [19:0] core_state_idx           = 20'hee01a;
  localparam logic [19:0] vector_state_idx         = 20'hee01b;
  localparam logic [21:0] system_control_addr       = {system_control_idx, 2'b00};
  localparam logic [21:0] request_sense_select_addr = {request_sense_select_idx, 2'b00};
  localparam logic [21:0] request_enable_addr       = {request_enable_idx, 2'b00};
  localparam logic [21:0] request_status_addr       = {request_status_idx, 2'b00};
  localparam logic [21:0] priority_level_a_addr     = {priority_level_a_idx, 2'b00};
  localparam logic [21:0] priority_level_b_addr     = {priority_level_b_idx, 2'b00};
  localparam logic [21:0] core_state_addr           = {core_state_idx, 2'b00};
  localparam logic [21:0] vector_state_addr         = {vector_state_idx, 2'b00};
  // ------------------------------------------------------------
  // reset values and fields
  // ------------------------------------------------------------
  localparam logic [7:0] system_control_rst = 8'h09;
  localparam logic [7:0] zero_rst           = 8'h00;
  localparam int         aux_bit_select_pos       = 3;
  localparam int         nonmaskable_edge_sel_pos = 2;
  localparam int         num_req                  = 6;
  localparam logic [7:0] req_field_mask           = 8'h3f;
  // ------------------------------------------------------------
  // vectors
  // ------------------------------------------------------------
  localparam logic [5:0] reset_vector_num = 6'h00;
  localparam logic [5:0] nmi_vector_num   = 6'h07;
  localparam logic [5:0] trap_vector_base = 6'h08;
  localparam logic [5:0] req_vector_base  = 6'h0c;
  localparam logic [5:0] int_vector_base  = 6'h14;
  localparam int         num_internal     = 36;
  localparam logic [23:0] reset_vector_lo = 24'h000000;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int run_hold_cyc       = 10;
  localparam logic [31:0] apb_zero  = 32'h0000_0000;
endpackage
`default_nettype wire

// >>> intc_properties.sv
/*
  concurrent checks on the controller ports.
  assumes binding onto reset_and_interrupt_control by name.
*/
`default_nettype none
module intc_properties (
  input wire logic        ref_clk_i,
  input wire logic        reset_n_i,
  input wire logic        chip_init_pin_n_i,
  input wire logic        watchdog_unit_overflow_i,
  input wire logic        trap_instruction_i,
  input wire logic [23:0] word_addr_i,
  input wire logic        word_access_i,
  input wire logic        core_hold_o,
  input wire logic        core_init_o,
  input wire logic        set_global_mask_o,
  input wire logic        vector_fetch_o,
  input wire logic [5:0]  vector_num_o,
  input wire logic        irq_req_o,
  input wire logic [5:0]  irq_vector_o,
  input wire logic [23:0] bus_addr_o
);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence pin_released;
    $rose(chip_init_pin_n_i) ##1 chip_init_pin_n_i [*2];
  endsequence
  sequence init_step;
    set_global_mask_o && vector_fetch_o && vector_num_o == intc_pkg::reset_vector_num;
  endsequence
  AST_HOLD_IN_RESET: assert property (!chip_init_pin_n_i [*4] |-> core_hold_o)
    else $error("core not held in reset");
  AST_EXIT_ON_RISE: assert property (pin_released |-> ##[1:8] core_init_o)
    else $error("no init after release");
  AST_INIT_VECTOR: assert property (core_init_o |-> init_step)
    else $error("init without mask or vector");
  AST_NO_IRQ_AT_INIT: assert property ((core_hold_o || core_init_o) |=> !irq_req_o)
    else $error("request after reset");
  AST_WATCHDOG_RESET: assert property ($rose(watchdog_unit_overflow_i) |-> ##[1:8] core_hold_o)
    else $error("no watchdog reset");
  AST_VECTOR_RANGE: assert property (irq_req_o |-> irq_vector_o inside {7, [12:17], [20:55]})
    else $error("vector outside map");
  AST_TRAP_MASK: assert property (trap_instruction_i |=> set_global_mask_o)
    else $error("trap left mask clear");
  AST_WORD_ALIGN: assert property (word_access_i |=> bus_addr_o == {$past(word_addr_i[23:1]), 1'b0})
    else $error("word address bit zero set");
endmodule
`default_nettype wire

// >>> intc_core_model.sv
/*
  cpu core model: instruction ends, exception taking, mask bits.
  assumes registered controller pulses.
*/
`default_nettype none
module intc_core_model (
  input  wire logic       ref_clk_i,
  input  wire logic       reset_n_i,
  input  wire logic       core_hold_i,
  input  wire logic       set_global_mask_i,
  input  wire logic       set_aux_mask_i,
  input  wire logic       irq_req_i,
  input  wire logic [5:0] irq_vector_i,
  output logic            instr_done_o,
  output logic            exc_taken_o,
  output logic [5:0]      exc_vector_o,
  output logic            global_mask_o,
  output logic            aux_mask_o,
  output int              taken_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // boundary every 8 cycles, software unmasks 4 cycles later
  // ------------------------------------------------------------
  logic [2:0] step;
  logic       edge_ok;
  assign edge_ok = !core_hold_i && step == 3'h3;
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      step          <= 3'h0;
      instr_done_o  <= 1'b0;
      exc_taken_o   <= 1'b0;
      exc_vector_o  <= 6'h00;
      global_mask_o <= 1'b1;
      aux_mask_o    <= 1'b1;
      taken_o       <= 0;
    end else begin
      step         <= core_hold_i ? 3'h0 : step + 3'h1;
      instr_done_o <= edge_ok;
      exc_taken_o  <= edge_ok && irq_req_i;
      if (edge_ok && irq_req_i) begin
        exc_vector_o <= irq_vector_i;
        taken_o      <= taken_o + 1;
      end
      if (set_global_mask_i) global_mask_o <= 1'b1;
      else if (step == 3'h7) global_mask_o <= 1'b0;
      if (set_aux_mask_i) aux_mask_o <= 1'b1;
      else if (step == 3'h7) aux_mask_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> reset_and_interrupt_control_bench.sv
/*
  bench: apb tasks, reset, request and exception tests.
  assumes package, design, core model and checker compiled first.
*/
`default_nettype none
module reset_and_interrupt_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i, reset_n_i, chip_init_pin_n_i, watchdog_unit_overflow_i, nonmaskable_pin_i;
  logic trap_instruction_i, word_access_i, psel, penable, pwrite, instr_done_i, exc_taken_i;
  logic global_mask_i, aux_mask_bit_i, pready, pslverr, core_hold_o, core_init_o, rerr;
  logic set_global_mask_o, set_aux_mask_o, irq_req_o;
  logic [5:0]  req_pin_n_i, exc_vector_i, irq_vector_o;
  logic [1:0]  trap_num_i;
  logic [23:0] word_addr_i, bus_addr_o;
  logic [21:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  int          errors, tests_run, taken;
  localparam logic [21:0] regs [6] = '{intc_pkg::system_control_addr, intc_pkg::request_sense_select_addr,
    intc_pkg::request_enable_addr, intc_pkg::request_status_addr, intc_pkg::priority_level_a_addr,
    intc_pkg::priority_level_b_addr};
  reset_and_interrupt_control reset_and_interrupt_control_inst (.*, .hw_standby_n_i(1'b1), .soft_standby_i(1'b0),
    .int_req_i('0), .int_level_i('0), .pstrb(4'hf), .vector_fetch_o(), .vector_num_o(), .vector_addr_o());
  intc_core_model intc_core_model_inst (.ref_clk_i, .reset_n_i, .core_hold_i(core_hold_o),
    .set_global_mask_i(set_global_mask_o), .set_aux_mask_i(set_aux_mask_o), .irq_req_i(irq_req_o),
    .irq_vector_i(irq_vector_o), .instr_done_o(instr_done_i), .exc_taken_o(exc_taken_i),
    .exc_vector_o(exc_vector_i), .global_mask_o(global_mask_i), .aux_mask_o(aux_mask_bit_i), .taken_o(taken));
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(input logic wr, input logic [21:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= {24'h000000, d};
    @(posedge ref_clk_i);
    penable <= 1'b1;
    do @(posedge ref_clk_i); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input string n, input logic [21:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk(n, {24'h000000, e}, rdat);
  endtask
  task automatic regs_chk(input logic rst);
    for (int i = 0; i < 6; i++) rdc("register", regs[i], rst ? (i == 0 ? 8'h09 : 8'h00) : (i == 3 ? 8'h00 : 8'hff));
  endtask
  task automatic wait_init();
    for (int n = 0; n < 50 && core_init_o !== 1'b1; n++) @(posedge ref_clk_i);
    chk("core init", 1, core_init_o);
  endtask
  task automatic wait_take(input logic [5:0] e);
    int c;
    c = taken;
    for (int n = 0; n < 80 && taken == c; n++) @(posedge ref_clk_i);
    chk("taken", c + 1, taken);
    chk("vector", {26'h0, e}, {26'h0, exc_vector_i});
  endtask
  task automatic idle_chk(input string n);
    int c;
    c = taken;
    repeat (20) @(posedge ref_clk_i);
    chk(n, c, taken);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ------------------------------------------------------------
  // clock, watchdog, tests
  // ------------------------------------------------------------
  initial begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    repeat (5000) @(posedge ref_clk_i);
    errors++;
    $display("[ERR] run expected done seen hang");
    results();
  end
  initial begin
    {reset_n_i, chip_init_pin_n_i, watchdog_unit_overflow_i, trap_instruction_i, word_access_i} = 5'h00;
    {psel, penable, pwrite, nonmaskable_pin_i, req_pin_n_i} = 10'h07f;
    {trap_num_i, word_addr_i, paddr, pwdata} = '0;
    repeat (2) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    repeat (12) @(posedge ref_clk_i);
    chk("core hold", 1, core_hold_o);
    chip_init_pin_n_i <= 1'b1;
    wait_init();
    regs_chk(1'b1);
    apb(1'b0, 22'h000000, 8'h00);
    chk("unmapped error", 1, rerr);
    for (int i = 0; i < 6; i++) apb(1'b1, regs[i], 8'hff);
    regs_chk(1'b0);
    watchdog_unit_overflow_i <= 1'b1;
    wait_init();
    watchdog_unit_overflow_i <= 1'b0;
    regs_chk(1'b1);
    $display("test registers done");
    for (int i = 0; i < 2; i++) begin
      req_pin_n_i <= 6'h3a;
      apb(1'b1, intc_pkg::priority_level_a_addr, i ? 8'h20 : 8'h00);
      idle_chk("disabled request");
      apb(1'b1, intc_pkg::request_enable_addr, 8'h05);
      wait_take(i ? 6'd14 : 6'd12);
      req_pin_n_i <= 6'h3f;
      apb(1'b1, intc_pkg::request_enable_addr, 8'h00);
      apb(1'b0, intc_pkg::request_status_addr, 8'h00);
      apb(1'b1, intc_pkg::request_status_addr, 8'h00);
    end
    apb(1'b1, intc_pkg::request_sense_select_addr, 8'h02);
    req_pin_n_i <= 6'h3d;
    repeat (3) @(posedge ref_clk_i);
    req_pin_n_i <= 6'h3f;
    rdc("edge flag", intc_pkg::request_status_addr, 8'h02);
    apb(1'b1, intc_pkg::request_status_addr, 8'h00);
    rdc("cleared flag", intc_pkg::request_status_addr, 8'h00);
    $display("test requests done");
    nonmaskable_pin_i <= 1'b0;
    wait_take(6'h07);
    apb(1'b1, intc_pkg::system_control_addr, 8'h0d);
    nonmaskable_pin_i <= 1'b1;
    wait_take(6'h07);
    nonmaskable_pin_i <= 1'b0;
    idle_chk("falling edge ignored");
    {trap_num_i, trap_instruction_i, word_access_i, word_addr_i} <= {2'h2, 2'h3, 24'h123457};
    @(posedge ref_clk_i);
    {trap_instruction_i, word_access_i} <= 2'h0;
    @(posedge ref_clk_i);
    chk("word address", 24'h123456, bus_addr_o);
    $display("test nonmaskable and trap done");
    results();
  end
endmodule
bind reset_and_interrupt_control intc_properties intc_properties_inst (.*);
`default_nettype wire
